// *** bench/reset_pin_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// board side: reset pin circuit and oscillator ticks
module reset_pin_partner #(
  parameter int TICK_DIV = 1
) (
  input wire logic core_clk,
  input wire logic pull_low,
  output logic external_reset_pin,
  output logic slow_osc_tick,
  output logic crystal_clk_tick
);
  int cnt = 0;
  // weak pull-up: a released pin reads high, never its last driven value
  assign external_reset_pin = ~pull_low;
  // ticks faster than real life so the settle count stays short
  assign slow_osc_tick = (cnt == 0);
  assign crystal_clk_tick = (cnt == 0);
  always @(posedge core_clk) begin
    cnt <= (cnt + 1 >= TICK_DIV) ? 0 : cnt + 1;
  end
endmodule
`default_nettype wire

// *** bench/test_config_word_and_reset_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_config_word_and_reset_control;
  import cfg_reset_pkg::*;
  logic core_clk = 0, srst = 1, prog_mode = 0, prog_wr = 0, prog_rd = 0, prog_bulk_erase = 0;
  logic [13:0] prog_addr = 0;
  logic [15:0] prog_wdata = 0, prog_rdata, calibration_q, r;
  logic power_on_event = 0, supply_drop_event = 0, watchdog_timeout = 0, sleep_active = 0;
  logic soft_supply_drop_enable = 0, watchdog_soft_enable = 0, pull_low = 0;
  logic sw_set_power_on_flag = 0, sw_set_drop_flag = 0, seen;
  wire logic slow_osc_tick, crystal_clk_tick, external_reset_pin;
  settings_t settings_q;
  reset_cause_t reset_cause_q;
  status_flags_t status_q;
  logic watchdog_run_q, core_reset_q, wake_resume_q, internal_osc_stop_q;
  logic data_erase_q, program_erase_q, pin_pullup_en_q, pin_digital_in_q;
  logic [31:0] lfsr = 32'h2651;
  logic [11:0] w;
  int n_fail = 0, comparisons = 0, cyc = 0, n;
  // ticks every other cycle so the design's tick gating is exercised
  localparam int TICK_DIV = 2;
  localparam int S_ERASE = 0, S_POWER = 1, S_DROP = 2, S_PIN = 3, S_WDOG = 4;

  always #25 core_clk = ~core_clk;

  config_word_and_reset_control config_word_and_reset_control_i (.core_clk(core_clk),
    .srst(srst), .prog_mode(prog_mode), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
    .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_bulk_erase(prog_bulk_erase),
    .prog_rdata(prog_rdata), .power_on_event(power_on_event),
    .supply_drop_event(supply_drop_event), .watchdog_timeout(watchdog_timeout),
    .sleep_active(sleep_active), .soft_supply_drop_enable(soft_supply_drop_enable),
    .watchdog_soft_enable(watchdog_soft_enable), .slow_osc_tick(slow_osc_tick),
    .crystal_clk_tick(crystal_clk_tick), .external_reset_pin(external_reset_pin),
    .sw_set_power_on_flag(sw_set_power_on_flag), .sw_set_drop_flag(sw_set_drop_flag),
    .settings_q(settings_q), .watchdog_run_q(watchdog_run_q), .core_reset_q(core_reset_q),
    .wake_resume_q(wake_resume_q), .reset_cause_q(reset_cause_q), .status_q(status_q),
    .internal_osc_stop_q(internal_osc_stop_q), .data_erase_q(data_erase_q),
    .program_erase_q(program_erase_q), .calibration_q(calibration_q),
    .pin_pullup_en_q(pin_pullup_en_q), .pin_digital_in_q(pin_digital_in_q));

  reset_pin_partner #(.TICK_DIV(TICK_DIV)) reset_pin_partner_i (.core_clk(core_clk),
    .pull_low(pull_low),
    .external_reset_pin(external_reset_pin), .slow_osc_tick(slow_osc_tick),
    .crystal_clk_tick(crystal_clk_tick));

  // ====================
  // model and compares
  function automatic settings_t exp_set(logic [11:0] v);
    exp_set = {v[11:8], ~v[7], ~v[6], v[5], ~v[4], v[3], v[2:0], v[2:0] == 3'h7 || v[2:0] == 3'h5};
  endfunction

  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk_val(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(logic got, logic exp);
    chk_val({15'h0, got}, {15'h0, exp});
  endtask

  task automatic report_and_stop();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ====================
  // programming port and sequencing helpers
  task automatic wr(logic [13:0] a, logic [15:0] d);
    @(posedge core_clk);
    prog_wr <= 1;
    prog_addr <= a;
    prog_wdata <= d;
    @(posedge core_clk);
    prog_wr <= 0;
  endtask

  task automatic rd(logic [13:0] a, output logic [15:0] d);
    @(posedge core_clk);
    prog_rd <= 1;
    prog_addr <= a;
    @(posedge core_clk);
    prog_rd <= 0;
    #1 d = prog_rdata;
  endtask

  // counts cycles until the merged reset lets go, bounded
  task automatic wait_rel();
    n = 0;
    #1;
    while (core_reset_q !== 1'b0 && n < 8000) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk_flag(core_reset_q, 0);
  endtask

  // raises one source, picked by number, for len cycles
  task automatic src(input int k, input int len);
    for (int j = len; j >= 0; j--) begin
      @(posedge core_clk);
      case (k)
        S_ERASE: prog_bulk_erase <= j > 0;
        S_POWER: power_on_event <= j > 0;
        S_DROP: supply_drop_event <= j > 0;
        S_PIN: pull_low <= j > 0;
        default: watchdog_timeout <= j > 0;
      endcase
    end
  endtask

  // ====================
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 0;
    wait_rel();
    prog_mode <= 1;
    rd(14'h2007, r);
    chk_val(r, 16'hffff);
    rd(14'h2008, r);
    chk_val(r, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      w = {lfsr[11:6], 1'b0, lfsr[4:3], 3'(i)};
      watchdog_soft_enable <= lfsr[12];
      wr(14'h2007, {lfsr[15:12], w});
      repeat (2) @(posedge core_clk);
      #1 chk_val(16'(settings_q), 16'(exp_set(w)));
      chk_flag(watchdog_run_q, w[3] | lfsr[12]);
      rd(14'h2007, r);
      chk_val(r, {4'hf, w});
    end
    prog_mode <= 0;
    watchdog_soft_enable <= 1;
    wr(14'h2007, 16'h0000);
    rd(14'h2007, r);
    chk_val(r, 16'h0000);
    prog_mode <= 1;
    rd(14'h2007, r);
    chk_val(r, {4'hf, w});
    wr(14'h2009, 16'h5a3c);
    wr(14'h2007, 16'h0000);
    src(S_ERASE, 1);
    seen = 0;
    repeat (4) begin
      #1 seen |= data_erase_q & program_erase_q;
      @(posedge core_clk);
    end
    chk_flag(seen, 1);
    rd(14'h2009, r);
    chk_val(r, 16'h5a3c);
    chk_val(calibration_q, 16'h5a3c);
    rd(14'h2007, r);
    chk_val(r, 16'hffff);
    // settle timer on, internal oscillator, pin reset selected, drop off
    wr(14'h2007, 16'h0024);
    src(S_POWER, 10);
    wait_rel();
    chk_flag(n >= 1984 * TICK_DIV && n <= 1984 * TICK_DIV + 30, 1);
    chk_val(16'(reset_cause_q), 16'(CAUSE_POWER_ON));
    chk_flag(status_q.power_on_flag_n, 0);
    chk_val(16'({pin_pullup_en_q, pin_digital_in_q}), 16'h0002);
    src(S_DROP, 20);
    #1 chk_flag(core_reset_q, 0);
    // drop always on, settle timer off: a drop must not pull it in
    wr(14'h2007, 16'h0334);
    src(S_DROP, 10);
    wait_rel();
    chk_flag(n < 40, 1);
    chk_val(16'(reset_cause_q), 16'(CAUSE_SUPPLY_DROP));
    chk_flag(status_q.supply_drop_flag_n, 0);
    src(S_PIN, 10);
    repeat (60) @(posedge core_clk);
    #1 chk_flag(core_reset_q, 0);
    src(S_PIN, 80);
    #1 chk_flag(core_reset_q & internal_osc_stop_q, 1);
    wait_rel();
    chk_val(16'(reset_cause_q), 16'(CAUSE_PIN_RUN));
    src(S_WDOG, 1);
    repeat (2) @(posedge core_clk);
    wait_rel();
    chk_val(16'(reset_cause_q), 16'(CAUSE_WDOG_RUN));
    chk_flag(status_q.timeout_flag, 0);
    sleep_active <= 1;
    src(S_WDOG, 1);
    seen = 0;
    repeat (4) begin
      #1 seen |= wake_resume_q;
      @(posedge core_clk);
    end
    chk_flag(seen & ~core_reset_q, 1);
    chk_val(16'(reset_cause_q), 16'(CAUSE_WDOG_SLEEP));
    chk_val(16'({status_q.timeout_flag, status_q.powerdown_flag}), 16'h0);
    // drop limited to run time is ignored while asleep
    wr(14'h2007, 16'h0234);
    src(S_DROP, 20);
    #1 chk_flag(core_reset_q, 0);
    src(S_PIN, 80);
    wait_rel();
    chk_val(16'(reset_cause_q), 16'(CAUSE_PIN_SLEEP));
    chk_val(16'({status_q.timeout_flag, status_q.powerdown_flag}), 16'h0002);
    // crystal mode: settle count first, then the crystal count
    sleep_active <= 0;
    wr(14'h2007, 16'h0022);
    src(S_POWER, 10);
    wait_rel();
    chk_flag(n >= 3008 * TICK_DIV && n <= 3008 * TICK_DIV + 40, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** shared/cfg_reset_defines.svh ***
`ifndef CFG_RESET_DEFINES_SVH
`define CFG_RESET_DEFINES_SVH

// =====================================================================
// configuration space addresses
`define CFG_WORD_ADDR 14'h2007
`define CAL_WORD_ADDR 14'h2009

// =====================================================================
// configuration word field positions
`define FLD_FAILSAFE 11
`define FLD_SWITCHOVER 10
`define FLD_DROP_HI 9
`define FLD_DROP_LO 8
`define FLD_DATA_LOCK 7
`define FLD_PROG_LOCK 6
`define FLD_PIN_SELECT 5
`define FLD_SETTLE_DIS 4
`define FLD_WDOG 3
`define FLD_OSC_HI 2
`define FLD_OSC_LO 0
`define CFG_IMPL_BITS 12
`define CFG_UNIMPL_READ 4'hf
`define CFG_ERASED 12'hfff
`define CAL_ERASED 16'hffff
`define BUS_IDLE_DATA 16'h0000

// =====================================================================
// timing
`define CLK_PERIOD_NS 50
`define PIN_FILTER_NS 2000
`define PIN_FILTER_CYC ((`PIN_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_TIME_US 64000
`define SLOW_OSC_HZ 31000
`define SETTLE_TICKS (`SETTLE_TIME_US * `SLOW_OSC_HZ / 1000000)
`define XTAL_CYCLES 1024

`endif

// *** shared/cfg_reset_pkg.sv ***
package cfg_reset_pkg;

  typedef enum logic [2:0] {
    OSC_LOW_POWER_XTAL = 3'h0,
    OSC_STANDARD_XTAL = 3'h1,
    OSC_HIGH_SPEED_XTAL = 3'h2,
    OSC_EXTERNAL_CLOCK = 3'h3,
    OSC_INTERNAL_IO_PINS = 3'h4,
    OSC_INTERNAL_CLOCK_OUT = 3'h5,
    OSC_RC_IO_PIN = 3'h6,
    OSC_RC_CLOCK_OUT = 3'h7
  } osc_mode_t;

  typedef enum logic [1:0] {
    DROP_OFF = 2'h0,
    DROP_SOFT = 2'h1,
    DROP_RUN_ONLY = 2'h2,
    DROP_ALWAYS = 2'h3
  } drop_mode_t;

  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_SETTLE = 4'h2,
    ST_XTAL = 4'h4,
    ST_RUN = 4'h8
  } seq_state_t;

  typedef enum logic [2:0] {
    CAUSE_POWER_ON = 3'h0,
    CAUSE_WDOG_RUN = 3'h1,
    CAUSE_WDOG_SLEEP = 3'h2,
    CAUSE_PIN_RUN = 3'h3,
    CAUSE_PIN_SLEEP = 3'h4,
    CAUSE_SUPPLY_DROP = 3'h5
  } reset_cause_t;

  typedef struct packed {
    logic failsafe_monitor_enable;
    logic clock_switchover_enable;
    drop_mode_t supply_drop_mode_select;
    logic data_protect;
    logic program_protect;
    logic reset_pin_select;
    logic settle_timer_en;
    logic watchdog_en;
    osc_mode_t osc_mode;
    logic clock_output_pin_en;
  } settings_t;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic power_on_flag_n;
    logic supply_drop_flag_n;
  } status_flags_t;

endpackage

// *** src/config_word_and_reset_control.sv ***
// How it works
// - programmed bit reads 0, erased reads 1
// - config word fixed, reachable only in programming
// - top four config bits read as ones
// - bit 11 enables fail-safe clock monitor
// - bit 10 enables oscillator switchover
// - two bits pick supply-drop reset mode
// - data lock; unlocking erases data memory
// - program lock; unlocking erases program memory
// - bit 5 makes pin reset input
// - settle timer enabled when bit 4 zero
// - watchdog forced on, else software enable
// - three bits select oscillator source
// - drop reset never enables settle timer
// - pin reset stops internal/RC oscillator
// - calibration word survives bulk erase
// - six distinct reset causes recorded
// - unaffected class untouched; others reset
// - watchdog wake resumes without register reset
// - timeout and powerdown flags mark cause
// - reset pin filtered against short pulses
// - watchdog reset never drives reset pin
// - settle timer holds 64 ms after power
// - settle timer first, then crystal timer
`timescale 1ns/1ps
`default_nettype none
`include "cfg_reset_defines.svh"
module config_word_and_reset_control (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic prog_mode,
  input wire logic [13:0] prog_addr,
  input wire logic [15:0] prog_wdata,
  input wire logic prog_wr,
  input wire logic prog_rd,
  input wire logic prog_bulk_erase,
  output logic [15:0] prog_rdata,
  input wire logic power_on_event,
  input wire logic supply_drop_event,
  input wire logic watchdog_timeout,
  input wire logic sleep_active,
  input wire logic soft_supply_drop_enable,
  input wire logic watchdog_soft_enable,
  input wire logic slow_osc_tick,
  input wire logic crystal_clk_tick,
  input wire logic external_reset_pin,
  input wire logic sw_set_power_on_flag,
  input wire logic sw_set_drop_flag,
  output cfg_reset_pkg::settings_t settings_q,
  output logic watchdog_run_q,
  output logic core_reset_q,
  output logic wake_resume_q,
  output cfg_reset_pkg::reset_cause_t reset_cause_q,
  output cfg_reset_pkg::status_flags_t status_q,
  output logic internal_osc_stop_q,
  output logic data_erase_q,
  output logic program_erase_q,
  output logic [15:0] calibration_q,
  output logic pin_pullup_en_q,
  output logic pin_digital_in_q
);
  import cfg_reset_pkg::*;

  // ===================================================================
  // configuration space access
  logic cfg_hit, cal_hit, cfg_we, cal_we;
  logic [`CFG_IMPL_BITS-1:0] cfg_word, cfg_wd;
  logic [15:0] cal_word;

  assign cfg_hit = prog_mode && prog_addr == `CFG_WORD_ADDR;
  assign cal_hit = prog_mode && prog_addr == `CAL_WORD_ADDR;
  // bulk erase returns the config word to all-erased; calibration stays
  assign cfg_we = (prog_mode && prog_bulk_erase) || (prog_wr && cfg_hit);
  assign cfg_wd = prog_bulk_erase ? `CFG_ERASED : prog_wdata[`CFG_IMPL_BITS-1:0];
  assign cal_we = prog_wr && cal_hit && !prog_bulk_erase;

  config_word_store u_store (
    .core_clk(core_clk),
    .srst(srst),
    .cfg_we(cfg_we),
    .cfg_wd(cfg_wd),
    .cal_we(cal_we),
    .cal_wd(prog_wdata),
    .rd_en(prog_rd && (cfg_hit || cal_hit)),
    .rd_cal(cal_hit),
    .rd_data_q(prog_rdata),
    .cfg_word(cfg_word),
    .cal_word(cal_word)
  );

  // ===================================================================
  // memory erase when a lock is lifted
  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_erase_q <= 1'b0;
      program_erase_q <= 1'b0;
    end else begin
      data_erase_q <= cfg_we && !cfg_word[`FLD_DATA_LOCK] && cfg_wd[`FLD_DATA_LOCK];
      program_erase_q <= cfg_we && !cfg_word[`FLD_PROG_LOCK] && cfg_wd[`FLD_PROG_LOCK];
    end
  end

  // ===================================================================
  // decode of the configuration word (0 = programmed, 1 = erased)
  osc_mode_t osc_sel;
  assign osc_sel = osc_mode_t'(cfg_word[`FLD_OSC_HI:`FLD_OSC_LO]);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      settings_q <= '0;
      calibration_q <= `CAL_ERASED;
      pin_pullup_en_q <= 1'b0;
      pin_digital_in_q <= 1'b1;
    end else begin
      settings_q.failsafe_monitor_enable <= cfg_word[`FLD_FAILSAFE];
      settings_q.clock_switchover_enable <= cfg_word[`FLD_SWITCHOVER];
      settings_q.supply_drop_mode_select <=
        drop_mode_t'(cfg_word[`FLD_DROP_HI:`FLD_DROP_LO]);
      settings_q.data_protect <= !cfg_word[`FLD_DATA_LOCK];
      settings_q.program_protect <= !cfg_word[`FLD_PROG_LOCK];
      settings_q.reset_pin_select <= cfg_word[`FLD_PIN_SELECT];
      // settle timer follows its own bit only, whatever the drop mode
      settings_q.settle_timer_en <= !cfg_word[`FLD_SETTLE_DIS];
      settings_q.watchdog_en <= cfg_word[`FLD_WDOG];
      settings_q.osc_mode <= osc_sel;
      settings_q.clock_output_pin_en <= osc_sel == OSC_RC_CLOCK_OUT
                                        || osc_sel == OSC_INTERNAL_CLOCK_OUT;
      calibration_q <= cal_word;
      pin_pullup_en_q <= cfg_word[`FLD_PIN_SELECT];
      pin_digital_in_q <= !cfg_word[`FLD_PIN_SELECT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) watchdog_run_q <= 1'b0;
    else watchdog_run_q <= settings_q.watchdog_en || watchdog_soft_enable;
  end

  // ===================================================================
  // reset sources
  logic por_lvl, drop_lvl, pin_lvl;
  logic por_prev_q, drop_prev_q, ext_prev_q, ext_rst_q;
  logic drop_act;

  level_filter #(.FILTER_CYC(1), .RST_VAL(1'b1)) u_por_sync (
    .core_clk(core_clk),
    .srst(srst),
    .raw_in(power_on_event),
    .level_q(por_lvl)
  );

  level_filter #(.FILTER_CYC(1), .RST_VAL(1'b0)) u_drop_sync (
    .core_clk(core_clk),
    .srst(srst),
    .raw_in(supply_drop_event),
    .level_q(drop_lvl)
  );

  // short glitches on the pin never reach the reset merge
  level_filter #(.FILTER_CYC(`PIN_FILTER_CYC), .RST_VAL(1'b1)) u_pin_filter (
    .core_clk(core_clk),
    .srst(srst),
    .raw_in(external_reset_pin),
    .level_q(pin_lvl)
  );

  always_comb begin
    case (settings_q.supply_drop_mode_select)
      DROP_ALWAYS: drop_act = drop_lvl;
      DROP_RUN_ONLY: drop_act = drop_lvl && !sleep_active;
      DROP_SOFT: drop_act = drop_lvl && soft_supply_drop_enable;
      default: drop_act = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ext_rst_q <= 1'b0;
      por_prev_q <= 1'b1;
      drop_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_rst_q <= settings_q.reset_pin_select && !pin_lvl;
      por_prev_q <= por_lvl;
      drop_prev_q <= drop_act;
      ext_prev_q <= ext_rst_q;
    end
  end

  logic por_rise, drop_rise, ext_rise, wdog_reset, wdog_wake;
  assign por_rise = por_lvl && !por_prev_q;
  assign drop_rise = drop_act && !drop_prev_q;
  assign ext_rise = ext_rst_q && !ext_prev_q;
  // a timeout in sleep is a wake-up and resets no register
  assign wdog_reset = watchdog_timeout && watchdog_run_q && !sleep_active;
  assign wdog_wake = watchdog_timeout && watchdog_run_q && sleep_active;

  // ===================================================================
  // start-up sequence
  seq_state_t seq_q, seq_d;
  logic [10:0] settle_cnt_q;
  logic [9:0] xtal_cnt_q;
  logic power_cause_q, power_src, is_crystal, settle_done, xtal_done;

  assign power_src = por_lvl || drop_act;
  assign is_crystal = settings_q.osc_mode == OSC_HIGH_SPEED_XTAL
                      || settings_q.osc_mode == OSC_STANDARD_XTAL
                      || settings_q.osc_mode == OSC_LOW_POWER_XTAL;
  assign settle_done = slow_osc_tick && settle_cnt_q == 11'(`SETTLE_TICKS - 1);
  assign xtal_done = crystal_clk_tick && xtal_cnt_q == 10'(`XTAL_CYCLES - 1);

  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      ST_HOLD: begin
        if (power_src || wdog_reset) seq_d = ST_HOLD;
        else if (power_cause_q && settings_q.settle_timer_en) seq_d = ST_SETTLE;
        else if (power_cause_q && is_crystal) seq_d = ST_XTAL;
        else seq_d = ST_RUN;
      end
      ST_SETTLE: begin
        if (power_src) seq_d = ST_HOLD;
        else if (settle_done) seq_d = is_crystal ? ST_XTAL : ST_RUN;
      end
      ST_XTAL: begin
        if (power_src) seq_d = ST_HOLD;
        else if (xtal_done) seq_d = ST_RUN;
      end
      ST_RUN: begin
        if (power_src || wdog_reset) seq_d = ST_HOLD;
      end
      default: seq_d = ST_HOLD;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) seq_q <= ST_HOLD;
    else seq_q <= seq_d;
  end

  always_ff @(posedge core_clk) begin
    if (srst) power_cause_q <= 1'b1;
    else if (power_src) power_cause_q <= 1'b1;
    else if (seq_d == ST_RUN) power_cause_q <= 1'b0;
  end

  // the settle count restarts whenever the supply falls away again
  always_ff @(posedge core_clk) begin
    if (srst || seq_q != ST_SETTLE || power_src) settle_cnt_q <= 11'h0;
    else if (slow_osc_tick) settle_cnt_q <= settle_cnt_q + 11'h1;
  end

  always_ff @(posedge core_clk) begin
    if (srst || seq_q != ST_XTAL || power_src) xtal_cnt_q <= 10'h0;
    else if (crystal_clk_tick) xtal_cnt_q <= xtal_cnt_q + 10'h1;
  end

  // timers keep running under a held pin, so release of the pin alone
  // starts execution at once; the unaffected register class takes no
  // part in this reset at all
  always_ff @(posedge core_clk) begin
    if (srst) core_reset_q <= 1'b1;
    else core_reset_q <= seq_d != ST_RUN || ext_rst_q;
  end

  // the pin is input only, so no internal reset ever drives it
  always_ff @(posedge core_clk) begin
    if (srst) wake_resume_q <= 1'b0;
    else wake_resume_q <= wdog_wake && !power_src;
  end

  always_ff @(posedge core_clk) begin
    if (srst) internal_osc_stop_q <= 1'b0;
    else internal_osc_stop_q <= ext_rst_q && !is_crystal
                                && settings_q.osc_mode != OSC_EXTERNAL_CLOCK;
  end

  // ===================================================================
  // cause record and status flags
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reset_cause_q <= CAUSE_POWER_ON;
      status_q <= '{timeout_flag: 1'b1, powerdown_flag: 1'b1,
                    power_on_flag_n: 1'b0, supply_drop_flag_n: 1'b1};
    end else if (por_rise) begin
      reset_cause_q <= CAUSE_POWER_ON;
      status_q <= '{timeout_flag: 1'b1, powerdown_flag: 1'b1,
                    power_on_flag_n: 1'b0,
                    supply_drop_flag_n: status_q.supply_drop_flag_n};
    end else if (drop_rise) begin
      reset_cause_q <= CAUSE_SUPPLY_DROP;
      status_q.timeout_flag <= 1'b1;
      status_q.powerdown_flag <= 1'b1;
      status_q.supply_drop_flag_n <= 1'b0;
      // a software set in the same cycle still lands on the other flag
      if (sw_set_power_on_flag) status_q.power_on_flag_n <= 1'b1;
    end else begin
      if (wdog_reset) begin
        reset_cause_q <= CAUSE_WDOG_RUN;
        status_q.timeout_flag <= 1'b0;
      end else if (wdog_wake) begin
        reset_cause_q <= CAUSE_WDOG_SLEEP;
        status_q.timeout_flag <= 1'b0;
        status_q.powerdown_flag <= 1'b0;
      end else if (ext_rise && sleep_active) begin
        reset_cause_q <= CAUSE_PIN_SLEEP;
        status_q.timeout_flag <= 1'b1;
        status_q.powerdown_flag <= 1'b0;
      end else if (ext_rise) begin
        reset_cause_q <= CAUSE_PIN_RUN;
      end
      if (sw_set_power_on_flag) status_q.power_on_flag_n <= 1'b1;
      if (sw_set_drop_flag) status_q.supply_drop_flag_n <= 1'b1;
    end
  end

  // ===================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_unimpl_reads_one:
    assert property (prog_rd && cfg_hit |=> prog_rdata[15:12] == 4'hf)
    else $error("unimplemented config bits not read as one");
  a_space_closed:
    assert property (prog_rd && !prog_mode |=> prog_rdata == 16'h0000)
    else $error("config space answered outside programming mode");
  a_failsafe_follows:
    assert property (prog_wr && cfg_hit && !prog_bulk_erase |-> ##2
      settings_q.failsafe_monitor_enable == $past(prog_wdata[11], 2))
    else $error("fail-safe enable does not follow bit 11");
  a_switchover_follows:
    assert property (prog_wr && cfg_hit && !prog_bulk_erase |-> ##2
      settings_q.clock_switchover_enable == $past(prog_wdata[10], 2))
    else $error("switchover enable does not follow bit 10");
  a_drop_off_quiet:
    assert property (settings_q.supply_drop_mode_select == DROP_OFF |-> !drop_act)
    else $error("drop reset active while disabled");
  a_pin_tied_off:
    assert property (!settings_q.reset_pin_select |=> !ext_rst_q)
    else $error("pin reset active while pin is digital input");
  a_osc_stop:
    assert property (ext_rst_q && settings_q.osc_mode[2] |=> internal_osc_stop_q)
    else $error("internal oscillator not stopped under pin reset");
  a_settle_length:
    assert property ($fell(seq_q == ST_SETTLE) && seq_q != ST_HOLD
      |-> $past(settle_cnt_q) == 11'(`SETTLE_TICKS - 1))
    else $error("settle timer ended early");
  a_xtal_after_settle:
    assert property ($rose(seq_q == ST_XTAL) && settings_q.settle_timer_en
      |-> $past(seq_q) == ST_SETTLE)
    else $error("crystal timer started before settle timer");
  a_merged_reset:
    assert property (seq_q != ST_RUN |-> core_reset_q)
    else $error("core released during start-up sequence");
  a_wake_no_reset:
    assert property (wdog_wake && seq_q == ST_RUN && !power_src && !ext_rst_q
      |=> wake_resume_q && !core_reset_q)
    else $error("watchdog wake applied a reset");
  a_power_flags:
    assert property (por_rise |=> !status_q.power_on_flag_n
      && status_q.timeout_flag && status_q.powerdown_flag)
    else $error("power-on flags wrong");
  c_settle_to_run: cover property (seq_q == ST_SETTLE ##[1:300] seq_q == ST_RUN);
  c_wdog_wake: cover property (wake_resume_q);
  c_pin_in_sleep: cover property (ext_rise && sleep_active);
endmodule
`default_nettype wire

// *** src/config_word_store.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cfg_reset_defines.svh"
module config_word_store (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cfg_we,
  input wire logic [`CFG_IMPL_BITS-1:0] cfg_wd,
  input wire logic cal_we,
  input wire logic [15:0] cal_wd,
  input wire logic rd_en,
  input wire logic rd_cal,
  output logic [15:0] rd_data_q,
  output logic [`CFG_IMPL_BITS-1:0] cfg_word,
  output logic [15:0] cal_word
);
  logic [`CFG_IMPL_BITS-1:0] cfg_mem_q;
  logic [15:0] cal_mem_q;
  logic cfg_valid_q, cal_valid_q;

  // non-volatile cells carry no reset; a cell not written since srst reads erased
  always_ff @(posedge core_clk) begin
    if (cfg_we) cfg_mem_q <= cfg_wd;
    if (cal_we) cal_mem_q <= cal_wd;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_valid_q <= 1'b0;
      cal_valid_q <= 1'b0;
    end else begin
      if (cfg_we) cfg_valid_q <= 1'b1;
      if (cal_we) cal_valid_q <= 1'b1;
    end
  end

  assign cfg_word = cfg_valid_q ? cfg_mem_q : `CFG_ERASED;
  assign cal_word = cal_valid_q ? cal_mem_q : `CAL_ERASED;

  always_ff @(posedge core_clk) begin
    if (srst) rd_data_q <= `BUS_IDLE_DATA;
    else if (!rd_en) rd_data_q <= `BUS_IDLE_DATA;
    else if (rd_cal) rd_data_q <= cal_word;
    else rd_data_q <= {`CFG_UNIMPL_READ, cfg_word};
  end
endmodule
`default_nettype wire

// *** src/level_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
module level_filter #(
  parameter int FILTER_CYC = 1,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic raw_in,
  output logic level_q
);
  logic s1_q, s2_q, s3_q;
  logic [5:0] cnt_q;

  always_ff @(posedge core_clk) begin
    s1_q <= raw_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // a new level must stand unchanged for FILTER_CYC agreeing samples
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= 6'h0;
      level_q <= RST_VAL;
    end else if (s2_q == s3_q && s3_q != level_q) begin
      if (cnt_q == 6'(FILTER_CYC - 1)) begin
        level_q <= s3_q;
        cnt_q <= 6'h0;
      end else begin
        cnt_q <= cnt_q + 6'h1;
      end
    end else begin
      cnt_q <= 6'h0;
    end
  end
endmodule
`default_nettype wire
